// ==== fetch_unit_model.sv ====
// Fetch unit model that competes for the shared memory port slot
`timescale 1ns/100ps
module fetch_unit_model (
  // Clock
  input  wire logic       clk_sys,
  // Request pattern: 0 idle, 1 always, 2 random
  input  wire logic [1:0] fetchMode,
  // Grant from the slot arbiter
  input  wire logic       fetchGo,
  output logic            fetchReq
);
  integer seed = 98573;
  initial fetchReq = 1'b0;
  // A random request is held until its grant shows
  always @(negedge clk_sys) begin
    if (fetchMode == 2'h0)
      fetchReq <= 1'b0;
    else if (fetchMode == 2'h1)
      fetchReq <= 1'b1;
    else if (!fetchReq || fetchGo)
      fetchReq <= 1'($random(seed));
  end
endmodule

// ==== instruction_issue_timing.sv ====
// Issue timing and hazard logic: cycle and stage counts, slot split, flag and multiplier stalls
//
// Notes on behaviour
// - Indexed and base-relative stores: 1 cycle, 4 stages, memory access may hit fetch.
// - Predecrement stores: 1 cycle, 5 stages, memory access may hit fetch.
// - Memory access meeting fetch in one slot splits the slot, never both at once.
// - Plain register arithmetic: 1 cycle, 5 stages, no slot contention; flag readers still get the flag hazard.
// - Flag-updating register arithmetic: 1 cycle, 5 stages.
// - Flag readers within two instructions after a flag update get a stall.
// - Register and immediate logic ops: 1 cycle, 5 stages, no slot contention; flag readers still get the flag hazard.
// - Register bit tests: 1 cycle, 5 stages, set flags, subject to flag hazard.
// - Byte memory logic ops: 3 cycles, 6 stages, memory access hits fetch.
// - Byte memory bit test: 3 cycles, 7 stages, flag hazard, hits fetch.
// - Multiply-accumulate: 2 cycles, 5 when contended, 8 stages, hits fetch.
// - Short multiply 1 (3) cycles 6 stages; double multiply 2 (5) cycles 8 stages.
// - Conditional branches 3 stages: delayed 2 or 1, plain 3 or 1 cycles.
// - Jumps and return 2 cycles 3 stages; calls 2 cycles 5 stages.
// - A flag-update contention costs exactly one extra cycle.
// - Larger multiply figure applies when the previous instruction also used multiplier.
`timescale 1ns/100ps
module instruction_issue_timing (
  // Clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  // Decoded instruction from fetch unit
  input  wire logic                          issueValid,
  input  wire issue_timing_pkg::issue_req_t  issueReq,
  output logic                               issueReady,
  // Fetch and memory port slot arbitration
  input  wire logic                          fetchReq,
  output logic                               fetchGo,
  output logic                               memAccessGo,
  // Timing of the accepted instruction
  output logic                               stallBubble,
  output issue_timing_pkg::issue_timing_t    issueTiming
);
  import issue_timing_pkg::*;

  typedef enum logic {ST_IDLE, ST_BUSY} issue_state_t;

  issue_state_t    state_ff, nxt_state;
  logic [CNT_W-1:0] remain_ff, nxt_remain;
  logic [CNT_W-1:0] extra_ff, nxt_extra;
  logic [1:0]      flagWin_ff, nxt_flagWin;
  logic            prevMul_ff, nxt_prevMul;
  logic            ready_ff, nxt_ready;
  logic            fetchGo_ff, nxt_fetchGo;
  logic            memGo_ff, nxt_memGo;
  logic            bubble_ff, nxt_bubble;
  issue_timing_t   timing_ff, nxt_timing;

  logic             accept;
  logic             hasMa;
  logic             setsFlags;
  logic             usesMul;
  logic [CNT_W-1:0] baseCyc;
  logic [CNT_W-1:0] stages;
  logic             flagHaz;
  logic             mulHaz;
  logic             split;
  logic [CNT_W-1:0] total;

  assign accept = issueValid && ready_ff;

  // Per-class figures
  always_comb begin
    hasMa     = 1'b0;
    setsFlags = 1'b0;
    usesMul   = 1'b0;
    baseCyc   = CYC_ONE;
    stages    = STG_FIVE;
    case (issueReq.cls)
      CLS_STORE_INDEXED: begin
        stages = STG_FOUR;
        hasMa  = 1'b1;
      end
      CLS_STORE_PREDEC: begin
        hasMa = 1'b1;
      end
      CLS_ARITH: begin
        stages = STG_FIVE;
      end
      CLS_ARITH_FLAGS: begin
        setsFlags = 1'b1;
      end
      CLS_LOGIC: begin
        stages = STG_FIVE;
      end
      CLS_BIT_TEST: begin
        setsFlags = 1'b1;
      end
      CLS_MEM_LOGIC: begin
        baseCyc = CYC_THREE;
        stages  = STG_SIX;
        hasMa   = 1'b1;
      end
      CLS_MEM_BIT_TEST: begin
        baseCyc   = CYC_THREE;
        stages    = STG_SEVEN;
        hasMa     = 1'b1;
        setsFlags = 1'b1;
      end
      CLS_MUL_ACCUM: begin
        baseCyc = prevMul_ff ? CYC_FIVE : CYC_TWO;
        stages  = STG_EIGHT;
        hasMa   = 1'b1;
        usesMul = 1'b1;
      end
      CLS_MUL_SHORT: begin
        baseCyc = prevMul_ff ? CYC_THREE : CYC_ONE;
        stages  = STG_SIX;
        hasMa   = 1'b1;
        usesMul = 1'b1;
      end
      CLS_MUL_DOUBLE: begin
        baseCyc = prevMul_ff ? CYC_FIVE : CYC_TWO;
        stages  = STG_EIGHT;
        hasMa   = 1'b1;
        usesMul = 1'b1;
      end
      CLS_BRANCH_COND: begin
        baseCyc = issueReq.taken ? CYC_THREE : CYC_ONE;
        stages  = STG_THREE;
      end
      CLS_BRANCH_DELAYED: begin
        baseCyc = issueReq.taken ? CYC_TWO : CYC_ONE;
        stages  = STG_THREE;
      end
      CLS_JUMP: begin
        baseCyc = CYC_TWO;
        stages  = STG_THREE;
      end
      CLS_CALL: begin
        baseCyc = CYC_TWO;
        stages  = STG_FIVE;
      end
      default: begin
        baseCyc = CYC_ONE;
        stages  = STG_FIVE;
      end
    endcase
  end

  // Contention terms
  always_comb begin
    flagHaz = issueReq.readsFlags && (flagWin_ff != FLAG_WINDOW_RST);
    mulHaz  = usesMul && prevMul_ff;
    split   = hasMa && fetchReq;
    total   = baseCyc + (flagHaz ? FLAG_PENALTY : CNT_RST)
            + (split ? SPLIT_PENALTY : CNT_RST);
  end

  // Next-state logic
  always_comb begin
    nxt_state   = state_ff;
    nxt_remain  = remain_ff;
    nxt_extra   = extra_ff;
    nxt_flagWin = flagWin_ff;
    nxt_prevMul = prevMul_ff;
    nxt_timing  = timing_ff;
    nxt_fetchGo = fetchReq;
    nxt_memGo   = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (accept) begin
          nxt_remain  = total - CYC_ONE;
          nxt_extra   = total - baseCyc;
          nxt_flagWin = {flagWin_ff[0], setsFlags};
          nxt_prevMul = usesMul;
          nxt_memGo   = hasMa;
          nxt_fetchGo = fetchReq && !hasMa;
          nxt_timing  = '{cycles: total, stages: stages, flagHazard: flagHaz,
                          mulHazard: mulHaz, slotSplit: split};
          nxt_state   = (total == CYC_ONE) ? ST_IDLE : ST_BUSY;
        end
      end
      ST_BUSY: begin
        nxt_remain = remain_ff - CYC_ONE;
        if (remain_ff == CYC_ONE) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    nxt_ready  = (nxt_state == ST_IDLE);
    nxt_bubble = (nxt_remain != CNT_RST) && (nxt_remain <= nxt_extra);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_ff   <= ST_IDLE;
      remain_ff  <= CNT_RST;
      extra_ff   <= CNT_RST;
      flagWin_ff <= FLAG_WINDOW_RST;
      prevMul_ff <= 1'b0;
      ready_ff   <= 1'b1;
      fetchGo_ff <= 1'b0;
      memGo_ff   <= 1'b0;
      bubble_ff  <= 1'b0;
      timing_ff  <= '0;
    end else begin
      state_ff   <= nxt_state;
      remain_ff  <= nxt_remain;
      extra_ff   <= nxt_extra;
      flagWin_ff <= nxt_flagWin;
      prevMul_ff <= nxt_prevMul;
      ready_ff   <= nxt_ready;
      fetchGo_ff <= nxt_fetchGo;
      memGo_ff   <= nxt_memGo;
      bubble_ff  <= nxt_bubble;
      timing_ff  <= nxt_timing;
    end
  end

  assign issueReady  = ready_ff;
  assign fetchGo     = fetchGo_ff;
  assign memAccessGo = memGo_ff;
  assign stallBubble = bubble_ff;
  assign issueTiming = timing_ff;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_plainIssue(instr_class_t c);
    accept && issueReq.cls == c && !fetchReq && !issueReq.readsFlags;
  endsequence

  a_split_slot: assert property (memAccessGo |-> !fetchGo)
    else $error("memory access and fetch granted in one slot");
  a_split_cost: assert property (accept && hasMa && fetchReq && baseCyc == CYC_ONE && !flagHaz
    |=> !issueReady ##1 issueReady)
    else $error("split slot did not cost one cycle");
  a_store_stages: assert property (s_plainIssue(CLS_STORE_INDEXED)
    |=> issueReady && issueTiming.stages == STG_FOUR)
    else $error("indexed store timing wrong");
  a_arith_single: assert property (s_plainIssue(CLS_ARITH)
    |=> issueReady && !stallBubble && issueTiming.cycles == CYC_ONE)
    else $error("plain arithmetic not single cycle");
  a_flag_stall: assert property (accept && issueReq.readsFlags && flagWin_ff != 2'h0
    |=> issueTiming.flagHazard && !issueReady ##[0:6] stallBubble)
    else $error("flag read hazard not flagged");
  a_mem_test_time: assert property (s_plainIssue(CLS_MEM_BIT_TEST)
    |=> !issueReady [*2] ##1 issueReady)
    else $error("memory bit test not three cycles");
  a_mul_contend: assert property (accept && issueReq.cls == CLS_MUL_DOUBLE && prevMul_ff
    |=> issueTiming.mulHazard && issueTiming.cycles >= CYC_FIVE)
    else $error("double multiply contention not applied");
  a_branch_taken: assert property (s_plainIssue(CLS_BRANCH_COND) ##0 issueReq.taken
    |=> !issueReady [*2] ##1 issueReady)
    else $error("taken branch not three cycles");
  a_bubble_holds: assert property (stallBubble |-> !issueReady)
    else $error("bubble while issue open");

endmodule

// ==== issue_timing_pkg.sv ====
// Package with instruction classes, timing figures and carrier structs for issue timing
package issue_timing_pkg;

  typedef enum logic [3:0] {
    CLS_STORE_INDEXED,
    CLS_STORE_PREDEC,
    CLS_ARITH,
    CLS_ARITH_FLAGS,
    CLS_LOGIC,
    CLS_BIT_TEST,
    CLS_MEM_LOGIC,
    CLS_MEM_BIT_TEST,
    CLS_MUL_ACCUM,
    CLS_MUL_SHORT,
    CLS_MUL_DOUBLE,
    CLS_BRANCH_COND,
    CLS_BRANCH_DELAYED,
    CLS_JUMP,
    CLS_CALL
  } instr_class_t;

  localparam int CNT_W = 4;

  localparam logic [CNT_W-1:0] CYC_ONE          = 4'h1;
  localparam logic [CNT_W-1:0] CYC_TWO          = 4'h2;
  localparam logic [CNT_W-1:0] CYC_THREE        = 4'h3;
  localparam logic [CNT_W-1:0] CYC_FIVE         = 4'h5;
  localparam logic [CNT_W-1:0] STG_THREE        = 4'h3;
  localparam logic [CNT_W-1:0] STG_FOUR         = 4'h4;
  localparam logic [CNT_W-1:0] STG_FIVE         = 4'h5;
  localparam logic [CNT_W-1:0] STG_SIX          = 4'h6;
  localparam logic [CNT_W-1:0] STG_SEVEN        = 4'h7;
  localparam logic [CNT_W-1:0] STG_EIGHT        = 4'h8;
  localparam logic [CNT_W-1:0] FLAG_PENALTY     = 4'h1;
  localparam logic [CNT_W-1:0] SPLIT_PENALTY    = 4'h1;
  localparam logic [1:0]       FLAG_WINDOW_RST  = 2'h0;
  localparam logic [CNT_W-1:0] CNT_RST          = 4'h0;

  typedef struct packed {
    instr_class_t cls;
    logic         taken;
    logic         readsFlags;
  } issue_req_t;

  typedef struct packed {
    logic [CNT_W-1:0] cycles;
    logic [CNT_W-1:0] stages;
    logic             flagHazard;
    logic             mulHazard;
    logic             slotSplit;
  } issue_timing_t;

endpackage

// ==== test_instruction_issue_timing.sv ====
// Self-checking testbench for the instruction issue timing block
`timescale 1ns/100ps
module test_instruction_issue_timing;
  import issue_timing_pkg::*;
  logic          clk_sys = 1'b0;
  logic          rst = 1'b1;
  logic          issueValid = 1'b0;
  issue_req_t    issueReq = '0;
  logic [1:0]    fetchMode = 2'h0;
  logic          issueReady, fetchReq, fetchGo, memAccessGo, stallBubble;
  issue_timing_t issueTiming;
  int            fail_count = 0;
  int            checks_done = 0;
  integer        seed = 98573;
  logic          h0 = 1'b0, h1 = 1'b0, prevMul = 1'b0;

  always #4 clk_sys = ~clk_sys;

  instruction_issue_timing instruction_issue_timing_inst (
    .clk_sys(clk_sys), .rst(rst), .issueValid(issueValid), .issueReq(issueReq),
    .issueReady(issueReady), .fetchReq(fetchReq), .fetchGo(fetchGo),
    .memAccessGo(memAccessGo), .stallBubble(stallBubble), .issueTiming(issueTiming));
  fetch_unit_model fetch_unit_model_inst (
    .clk_sys(clk_sys), .fetchMode(fetchMode), .fetchGo(fetchGo), .fetchReq(fetchReq));

  function automatic logic isMem(instr_class_t c);
    return c inside {CLS_STORE_INDEXED, CLS_STORE_PREDEC, CLS_MEM_LOGIC, CLS_MEM_BIT_TEST,
                     CLS_MUL_ACCUM, CLS_MUL_SHORT, CLS_MUL_DOUBLE};
  endfunction
  function automatic logic isMul(instr_class_t c);
    return c inside {CLS_MUL_ACCUM, CLS_MUL_SHORT, CLS_MUL_DOUBLE};
  endfunction
  function automatic logic setsFlags(instr_class_t c);
    return c inside {CLS_ARITH_FLAGS, CLS_BIT_TEST, CLS_MEM_BIT_TEST};
  endfunction
  // Cycles in the upper nibble, stages in the lower
  function automatic logic [7:0] baseTiming(instr_class_t c, logic tk, logic mul);
    case (c)
      CLS_STORE_INDEXED: return 8'h14;
      CLS_MEM_LOGIC: return 8'h36;
      CLS_MEM_BIT_TEST: return 8'h37;
      CLS_MUL_ACCUM, CLS_MUL_DOUBLE: return mul ? 8'h58 : 8'h28;
      CLS_MUL_SHORT: return mul ? 8'h36 : 8'h16;
      CLS_BRANCH_COND: return tk ? 8'h33 : 8'h13;
      CLS_BRANCH_DELAYED: return tk ? 8'h23 : 8'h13;
      CLS_JUMP: return 8'h23;
      CLS_CALL: return 8'h25;
      default: return 8'h15;
    endcase
  endfunction

  task automatic note(logic ok, logic [15:0] got, logic [15:0] exp);
    checks_done++;
    if (!ok) begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmpTiming(issue_timing_t got, issue_timing_t exp);
    note(got === exp, 16'(got), 16'(exp));
  endtask
  task automatic cmpBit(logic got, logic exp);
    note(got === exp, 16'(got), 16'(exp));
  endtask
  task automatic cmpCount(logic [3:0] got, logic [3:0] exp);
    note(got === exp, 16'(got), 16'(exp));
  endtask

  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic setMode(logic [1:0] m);
    issueValid = 1'b0;
    fetchMode = m;
    repeat (2) @(negedge clk_sys);
  endtask

  // Offers one instruction and follows it until the next may be taken
  task automatic issue(instr_class_t c, logic tk, logic rf);
    issue_timing_t exp;
    logic          fr, ms;
    int            n;
    issueValid = 1'b1;
    issueReq = '{cls: c, taken: tk, readsFlags: rf};
    @(posedge clk_sys);
    fr = fetchReq;
    @(negedge clk_sys);
    ms = isMul(c) && prevMul;
    exp.flagHazard = rf && (h0 || h1);
    exp.mulHazard = ms;
    exp.slotSplit = isMem(c) && fr;
    {exp.cycles, exp.stages} = baseTiming(c, tk, ms);
    exp.cycles = exp.cycles + CNT_W'(exp.flagHazard) + CNT_W'(exp.slotSplit);
    cmpTiming(issueTiming, exp);
    cmpBit(memAccessGo, isMem(c));
    cmpBit(fetchGo, fr && !isMem(c));
    prevMul = isMul(c);
    h1 = h0;
    h0 = setsFlags(c);
    n = 1;
    while (issueReady !== 1'b1) begin
      cmpBit(stallBubble, (exp.cycles - n) <= (exp.flagHazard + exp.slotSplit));
      issueReq = issue_req_t'(6'($random(seed)));
      @(negedge clk_sys);
      n++;
      if (n > 20) begin
        fail_count++;
        stop_test();
      end
    end
    cmpCount(4'(n), exp.cycles);
    cmpBit(stallBubble, 1'b0);
  endtask

  always @(negedge clk_sys)
    if (!rst) cmpBit(fetchGo && memAccessGo, 1'b0);

  initial begin
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys);
    cmpBit(issueReady, 1'b1);
    for (int m = 0; m < 2; m++) begin
      setMode(2'(m));
      for (int c = 0; c < 15; c++) begin
        issue(instr_class_t'(c), 1'b1, 1'b0);
        issue(instr_class_t'(c), 1'b0, 1'b0);
      end
    end
    setMode(2'h0);
    issue(CLS_ARITH_FLAGS, 1'b0, 1'b0);
    issue(CLS_LOGIC, 1'b0, 1'b1);
    issue(CLS_ARITH, 1'b0, 1'b1);
    issue(CLS_ARITH, 1'b0, 1'b1);
    issue(CLS_MEM_BIT_TEST, 1'b0, 1'b1);
    issue(CLS_BIT_TEST, 1'b0, 1'b1);
    issue(CLS_MUL_SHORT, 1'b0, 1'b1);
    setMode(2'h2);
    repeat (300)
      issue(instr_class_t'(4'($unsigned($random(seed)) % 15)), 1'($random(seed)),
            1'($random(seed)));
    issueValid = 1'b0;
    stop_test();
  end
endmodule
